/* File: dv/rlsc_properties.sv */
// Port-level checks for the wakeup timer and brownout control block.
// Assumes one clock domain and the register map of rlsc_pkg.
`default_nettype none
module rlsc_properties (
    input wire logic ref_clk,
    input wire logic rst,
    input wire rlsc_pkg::rlsc_bus_s bus,
    input wire logic [7:0] rdata,
    input wire logic slow_tick_in,
    input wire logic fast_tick_in,
    input wire logic brownout_in,
    input wire logic stop_mode,
    input wire logic wakeup_irq,
    input wire logic brownout_irq,
    input wire logic irq,
    input wire logic brownout_reset_req,
    input wire logic bandgap_buffer_enable,
    input wire logic brownout_stop_active
);
    // -----
    // Helpers
    // -----
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Only the first brownout write counts for the write-once master bit.
    logic once_seen;
    logic master_w;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            once_seen <= 1'b0;
            master_w <= 1'b0;
        end
        else if (bus.wr && bus.addr == rlsc_pkg::ADDR_BROWNOUT && !once_seen)
        begin
            once_seen <= 1'b1;
            master_w <= bus.wdata[2];
        end
    end
    sequence s_rd(a);
        bus.rd && bus.addr == a;
    endsequence
    sequence s_wr(a);
        bus.wr && bus.addr == a;
    endsequence
    wake_rsvd_a: assert property (s_rd(rlsc_pkg::ADDR_WAKEUP) |=>
        rdata[6] == 1'b0 && rdata[3] == 1'b0) else $error("wakeup rsvd");
    brn_rsvd_a: assert property (s_rd(rlsc_pkg::ADDR_BROWNOUT) |=>
        rdata[6] == 1'b0 && rdata[1] == 1'b0) else $error("brownout rsvd");
    unmapped_rd_a: assert property (bus.rd && bus.addr > 4'h3 |=>
        rdata == 8'h00) else $error("unmapped read not zero");
    master_rd_a: assert property (s_rd(rlsc_pkg::ADDR_BROWNOUT) ##0
        once_seen |=> rdata[2] == master_w) else $error("master moved");
    master_off_a: assert property (once_seen && !master_w |->
        !brownout_stop_active && !brownout_reset_req) else $error("master");
    bgbuf_copy_a: assert property (s_wr(rlsc_pkg::ADDR_BROWNOUT) ##1
        !bus.wr |=> bandgap_buffer_enable == $past(bus.wdata[0], 2))
        else $error("bandgap buffer enable");
    wirq_gate_a: assert property (s_wr(rlsc_pkg::ADDR_WAKEUP) ##0
        !bus.wdata[4] |-> ##2 !wakeup_irq) else $error("wakeup irq");
    birq_gate_a: assert property (s_wr(rlsc_pkg::ADDR_BROWNOUT) ##0
        !bus.wdata[5] |-> ##2 !brownout_irq) else $error("brownout irq");
    irq_mask_a: assert property (s_wr(rlsc_pkg::ADDR_IRQ_MASK) ##0
        bus.wdata[1:0] == 2'b00 |-> ##2 !irq) else $error("irq mask");
endmodule : rlsc_properties
bind rlsc_top rlsc_properties i_props (.ref_clk(ref_clk), .rst(rst),
    .bus(bus), .rdata(rdata), .slow_tick_in(slow_tick_in),
    .fast_tick_in(fast_tick_in), .brownout_in(brownout_in),
    .stop_mode(stop_mode), .wakeup_irq(wakeup_irq), .irq(irq),
    .brownout_irq(brownout_irq), .brownout_reset_req(brownout_reset_req),
    .bandgap_buffer_enable(bandgap_buffer_enable),
    .brownout_stop_active(brownout_stop_active));
`default_nettype wire

/* File: dv/rlsc_top_tb.sv */
// Self-checking bench for the wakeup timer and brownout control block.
// Assumes reads answer one cycle later and the block never stalls.
`default_nettype none
module rlsc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    rlsc_pkg::rlsc_bus_s bus = '0;
    logic [1:0] tk = 2'b00;
    logic bo = 1'b0;
    logic stp = 1'b0;
    logic [7:0] rdata;
    logic wirq, birq, irq, rreq, bgb, sact;
    logic rd_d = 1'b0;
    logic [7:0] q[$];
    int mismatches = 0;
    int total_checks = 0;
    rlsc_top i_rlsc_top (.ref_clk(ref_clk), .rst(rst), .bus(bus),
        .rdata(rdata), .slow_tick_in(tk[0]), .fast_tick_in(tk[1]),
        .brownout_in(bo), .stop_mode(stp), .wakeup_irq(wirq),
        .brownout_irq(birq), .irq(irq), .brownout_reset_req(rreq),
        .bandgap_buffer_enable(bgb), .brownout_stop_active(sact));
    initial forever #20 ref_clk = ~ref_clk;
    // -----
    // Tasks
    // -----
    task automatic chk(input logic [7:0] seen, exp, input string what);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task results;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk);
        bus.wr <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        q.push_back(e);
        @(posedge ref_clk);
        bus.rd <= 1'b0;
    endtask : rd
    task idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : idle
    // Random pulse widths keep the tick edges off any fixed phase.
    task tick(input int f, input int n);
        int g;
        repeat (n)
        begin
            g = 2 + $urandom % 3;
            tk[f] <= 1'b1;
            idle(g);
            tk[f] <= 1'b0;
            idle(g);
        end
    endtask : tick
    task do_reset;
        rst <= 1'b1;
        idle(16);
        rst <= 1'b0;
    endtask : do_reset
    always @(posedge ref_clk)
    begin
        if (rd_d)
            chk(rdata, q.pop_front(), "rdata");
        rd_d <= bus.rd;
    end
    initial
    begin
        repeat (60000) @(posedge ref_clk);
        mismatches++;
        results();
    end
    // -----
    // Tests
    // -----
    initial
    begin
        logic [7:0] v;
        logic [7:0] bg;
        logic [2:0] c;
        logic f;
        int p;
        void'($urandom(61955));
        do_reset();
        for (int a = 0; a < 5; a++)
            rd(4'(a), 8'h00);
        wr(4'h9, 8'hFF);
        rd(4'h9, 8'h00);
        $display("test reset values done");
        wr(rlsc_pkg::ADDR_IRQ_MASK, 8'h01);
        for (int k = 1; k < 10; k++)
        begin
            f = k > 7;
            c = 3'(f ? k - 7 : k);
            v = {2'b00, f, c[0], 1'b0, c};
            p = (f ? 256 : 8) << (c == 3'h1 ? 0 : c);
            wr(rlsc_pkg::ADDR_WAKEUP, v);
            tick(f, p - 2);
            idle(6);
            rd(rlsc_pkg::ADDR_WAKEUP, v);
            tick(f, 2);
            idle(6);
            rd(rlsc_pkg::ADDR_WAKEUP, v | 8'h80);
            chk(8'(wirq), 8'(c[0]), "wakeup_irq");
            rd(rlsc_pkg::ADDR_IRQ_STATUS, 8'h01);
            chk(8'(irq), 8'h01, "irq");
            wr(rlsc_pkg::ADDR_IRQ_STATUS, 8'h01);
            wr(rlsc_pkg::ADDR_WAKEUP, 8'h40);
            rd(rlsc_pkg::ADDR_WAKEUP, 8'h00);
            chk(8'(irq), 8'h00, "irq");
        end
        $display("test wakeup done");
        bg = 8'($urandom % 2);
        wr(rlsc_pkg::ADDR_IRQ_MASK, 8'h02);
        wr(rlsc_pkg::ADDR_BROWNOUT, 8'h3C | bg);
        rd(rlsc_pkg::ADDR_BROWNOUT, 8'h3C | bg);
        chk(8'(bgb), bg, "bandgap");
        chk(8'(sact), 8'h01, "stop_active");
        bo <= 1'b1;
        idle(6);
        rd(rlsc_pkg::ADDR_BROWNOUT, 8'hBC | bg);
        chk(8'(birq), 8'h01, "brownout_irq");
        chk(8'(rreq), 8'h01, "reset_req");
        chk(8'(irq), 8'h01, "irq");
        bo <= 1'b0;
        idle(4);
        wr(rlsc_pkg::ADDR_BROWNOUT, 8'h41);
        rd(rlsc_pkg::ADDR_BROWNOUT, 8'h15);
        chk(8'(rreq), 8'h00, "reset_req");
        chk(8'(sact), 8'h00, "stop_active");
        stp <= 1'b1;
        bo <= 1'b1;
        idle(6);
        rd(rlsc_pkg::ADDR_BROWNOUT, 8'h15);
        stp <= 1'b0;
        idle(6);
        rd(rlsc_pkg::ADDR_BROWNOUT, 8'h95);
        chk(8'(rreq), 8'h01, "reset_req");
        bo <= 1'b0;
        idle(4);
        rd(rlsc_pkg::ADDR_IRQ_STATUS, 8'h02);
        wr(rlsc_pkg::ADDR_IRQ_STATUS, 8'h02);
        wr(rlsc_pkg::ADDR_BROWNOUT, 8'h40);
        rd(rlsc_pkg::ADDR_BROWNOUT, 8'h14);
        rd(rlsc_pkg::ADDR_IRQ_STATUS, 8'h00);
        wr(rlsc_pkg::ADDR_IRQ_MASK, 8'h00);
        chk(8'(irq), 8'h00, "irq");
        $display("test brownout done");
        do_reset();
        wr(rlsc_pkg::ADDR_BROWNOUT, 8'h00);
        wr(rlsc_pkg::ADDR_BROWNOUT, 8'h1C);
        bo <= 1'b1;
        idle(6);
        rd(rlsc_pkg::ADDR_BROWNOUT, 8'h08);
        chk(8'(rreq), 8'h00, "reset_req");
        bo <= 1'b0;
        $display("test write once done");
        results();
    end
endmodule : rlsc_top_tb
`default_nettype wire

/* File: logic/rlsc_top.sv */
// Periodic wakeup timer and brownout detect control registers.
// Assumes the tick and detect inputs come from other clock domains.
// Assumes the register port strobes are one cycle and never overlap.
//
// Summary of operation
// - Timeout sets read-only flag bit seven.
// - Writing one to bit six clears flag.
// - Bit five selects timer counting source.
// - Bit four gates wakeup interrupt requests.
// - Period code zero disables, else 8ms-1.024s.
// - Fast source periods 256 to 32768 ticks.
// - First timeout may be up to one tick early, or sooner after a period change.
// - Detect sets brownout flag when master enabled.
// - Writing one to bit six clears brownout.
// - Bit five enables brownout interrupt request.
// - Write-once reset enable forces system reset.
// - Bit three keeps detection during stop.
// - Write-once master enable qualifies brownout logic.
// - Bit zero enables bandgap buffer.
// - Write-once bits take first write only.
//
// Design decisions made here: the address map and the plain strobed port.
`default_nettype none
module rlsc_top #(
    parameter int unsigned COUNT_W = 16
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire rlsc_pkg::rlsc_bus_s bus,
    output logic [7:0] rdata,
    input wire logic slow_tick_in,
    input wire logic fast_tick_in,
    input wire logic brownout_in,
    input wire logic stop_mode,
    output logic wakeup_irq,
    output logic brownout_irq,
    output logic irq,
    output logic brownout_reset_req,
    output logic bandgap_buffer_enable,
    output logic brownout_stop_active
);
    // ------------------------------------------------------------
    // Input synchronisers and edge detection
    // ------------------------------------------------------------
    logic [1:0] slow_sync;
    logic [1:0] fast_sync;
    logic [1:0] bo_sync;
    logic slow_last;
    logic fast_last;

    // Two flops per pin; only the second flop feeds any logic, so a
    // metastable first stage never reaches the counters.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            slow_sync <= 2'h0;
            slow_last <= 1'b0;
        end
        else
        begin
            slow_sync <= {slow_sync[0], slow_tick_in};
            slow_last <= slow_sync[1];
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            fast_sync <= 2'h0;
            fast_last <= 1'b0;
        end
        else
        begin
            fast_sync <= {fast_sync[0], fast_tick_in};
            fast_last <= fast_sync[1];
        end
    end

    // The brownout pin is a level, so no edge memory is kept for it.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            bo_sync <= 2'h0;
        else
            bo_sync <= {bo_sync[0], brownout_in};
    end

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (COUNT_W < rlsc_pkg::COUNT_W_MIN)
    begin : g_count_w_check
        $error("COUNT_W is too narrow for the longest period");
    end

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic wakeup_timeout_flag;
    logic wakeup_clock_select;
    logic wakeup_irq_enable;
    logic [2:0] wakeup_period_select;
    logic brownout_flag;
    logic brownout_irq_enable;
    logic brownout_reset_enable;
    logic brownout_stop_enable;
    logic brownout_master_enable;
    logic bgbuf;
    logic once_done;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [COUNT_W-1:0] tick_count;
    logic [COUNT_W-1:0] period_end;
    logic timeout;
    logic tick;

    // Every register uses the same write decode.
    function automatic logic is_write(input rlsc_pkg::rlsc_bus_s b,
                                      input logic [3:0] a);
        return b.wr && b.addr == a;
    endfunction : is_write

    wire wr_wake = is_write(bus, rlsc_pkg::ADDR_WAKEUP);
    wire wr_bo = is_write(bus, rlsc_pkg::ADDR_BROWNOUT);
    // Both sources count rising edges; the slow tick is one kHz.
    assign tick = wakeup_clock_select ? (fast_sync[1] & ~fast_last)
                                      : (slow_sync[1] & ~slow_last);

    // Slow periods in 1 ms ticks and fast periods in fast ticks.
    function automatic logic [15:0] period_len(input logic [2:0] code,
                                              input logic fast);
        logic [15:0] s;
        logic [15:0] f;
        s = 16'h0000;
        f = 16'h0000;
        unique case (code)
            3'h1:
            begin
                s = rlsc_pkg::SLOW_LEN_1;
                f = rlsc_pkg::FAST_LEN_1;
            end
            3'h2:
            begin
                s = rlsc_pkg::SLOW_LEN_2;
                f = rlsc_pkg::FAST_LEN_2;
            end
            3'h3:
            begin
                s = rlsc_pkg::SLOW_LEN_3;
                f = rlsc_pkg::FAST_LEN_3;
            end
            3'h4:
            begin
                s = rlsc_pkg::SLOW_LEN_4;
                f = rlsc_pkg::FAST_LEN_4;
            end
            3'h5:
            begin
                s = rlsc_pkg::SLOW_LEN_5;
                f = rlsc_pkg::FAST_LEN_5;
            end
            3'h6:
            begin
                s = rlsc_pkg::SLOW_LEN_6;
                f = rlsc_pkg::FAST_LEN_6;
            end
            3'h7:
            begin
                s = rlsc_pkg::SLOW_LEN_7;
                f = rlsc_pkg::FAST_LEN_7;
            end
            default:
            begin
                s = 16'h0000;
                f = 16'h0000;
            end
        endcase
        return fast ? f : s;
    endfunction : period_len

    // ------------------------------------------------------------
    // Periodic timer
    // ------------------------------------------------------------
    // The count is cleared only at code zero and at timeout, not when
    // the period changes between nonzero codes, so the first timeout after
    // such a change can come on the next tick; started from code zero it can
    // be up to one tick short.
    assign period_end = COUNT_W'(period_len(wakeup_period_select,
                                            wakeup_clock_select));
    assign timeout = tick && wakeup_period_select != rlsc_pkg::PERIOD_OFF
        && tick_count + COUNT_W'(1) >= period_end;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            tick_count <= '0;
        else if (wakeup_period_select == rlsc_pkg::PERIOD_OFF)
            tick_count <= '0;
        else if (timeout)
            tick_count <= '0;
        else if (tick)
            tick_count <= tick_count + COUNT_W'(1);
    end

    // Set wins over the ack, so a timeout in the ack cycle is not lost.

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            wakeup_timeout_flag <= 1'b0;
        else if (timeout)
            wakeup_timeout_flag <= 1'b1;
        else if (wr_wake && bus.wdata[rlsc_pkg::B_ACK])
            wakeup_timeout_flag <= 1'b0;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            wakeup_clock_select <= rlsc_pkg::WAKEUP_RESET[rlsc_pkg::B_CLKSEL];
            wakeup_irq_enable <= rlsc_pkg::WAKEUP_RESET[rlsc_pkg::B_WIRQEN];
            wakeup_period_select <= rlsc_pkg::WAKEUP_RESET[2:0];
        end
        else if (wr_wake)
        begin
            wakeup_clock_select <= bus.wdata[rlsc_pkg::B_CLKSEL];
            wakeup_irq_enable <= bus.wdata[rlsc_pkg::B_WIRQEN];
            wakeup_period_select <= bus.wdata[2:0];
        end
    end

    // ------------------------------------------------------------
    // Brownout control
    // ------------------------------------------------------------
    // Detection in stop mode is suppressed unless the stop enable is set.
    wire bo_event = bo_sync[1] && brownout_master_enable
        && (!stop_mode || brownout_stop_enable);
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            brownout_flag <= 1'b0;
        else if (bo_event)
            brownout_flag <= 1'b1;
        else if (wr_bo && bus.wdata[rlsc_pkg::B_ACK])
            brownout_flag <= 1'b0;
    end

    // Bit one is reserved and is never stored.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            brownout_irq_enable <= rlsc_pkg::BROWNOUT_RESET[rlsc_pkg::B_BIRQEN];
            brownout_stop_enable <= rlsc_pkg::BROWNOUT_RESET[rlsc_pkg::B_STOPEN];
            bgbuf <= rlsc_pkg::BROWNOUT_RESET[rlsc_pkg::B_BGBUF];
        end
        else if (wr_bo)
        begin
            brownout_irq_enable <= bus.wdata[rlsc_pkg::B_BIRQEN];
            brownout_stop_enable <= bus.wdata[rlsc_pkg::B_STOPEN];
            bgbuf <= bus.wdata[rlsc_pkg::B_BGBUF];
        end
    end

    // One flag guards both write-once bits: any first write, even of
    // zeros, locks them until the next reset.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            brownout_reset_enable <= rlsc_pkg::BROWNOUT_RESET[rlsc_pkg::B_RSTEN];
            brownout_master_enable <=
                rlsc_pkg::BROWNOUT_RESET[rlsc_pkg::B_MASTER];
            once_done <= 1'b0;
        end
        else if (wr_bo && !once_done)
        begin
            brownout_reset_enable <= bus.wdata[rlsc_pkg::B_RSTEN];
            brownout_master_enable <= bus.wdata[rlsc_pkg::B_MASTER];
            once_done <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    // A status bit rises on the cycle its event starts; a clear in the
    // same cycle loses, so no event is missed.
    wire wr_st = is_write(bus, rlsc_pkg::ADDR_IRQ_STATUS);
    wire [1:0] ev = {bo_event & ~brownout_flag, timeout};
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            irq_status <= 2'h0;
        else
            irq_status <= ev | (irq_status & ~(wr_st ? bus.wdata[1:0] : 2'h0));
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            irq_mask <= 2'h0;
        else if (is_write(bus, rlsc_pkg::ADDR_IRQ_MASK))
            irq_mask <= bus.wdata[1:0];
    end

    // ------------------------------------------------------------
    // Outputs and read port
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            wakeup_irq <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            wakeup_irq <= wakeup_timeout_flag && wakeup_irq_enable;
            irq <= |(irq_status & irq_mask);
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            brownout_irq <= 1'b0;
            brownout_reset_req <= 1'b0;
            bandgap_buffer_enable <= 1'b0;
            brownout_stop_active <= 1'b0;
        end
        else
        begin
            brownout_irq <= brownout_flag && brownout_irq_enable;
            brownout_reset_req <= brownout_flag && brownout_reset_enable
                && brownout_master_enable;
            bandgap_buffer_enable <= bgbuf;
            brownout_stop_active <= brownout_master_enable
                && brownout_stop_enable;
        end
    end

    // Read data is zero outside the answer cycle, so a stale value is
    // never mistaken for a fresh answer.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            rdata <= 8'h00;
        else if (bus.rd)
        begin
            unique case (bus.addr)
                rlsc_pkg::ADDR_WAKEUP:
                    rdata <= {wakeup_timeout_flag, 1'b0, wakeup_clock_select,
                              wakeup_irq_enable, 1'b0, wakeup_period_select};
                rlsc_pkg::ADDR_BROWNOUT:
                    rdata <= {brownout_flag, 1'b0, brownout_irq_enable,
                              brownout_reset_enable, brownout_stop_enable,
                              brownout_master_enable, 1'b0, bgbuf};
                rlsc_pkg::ADDR_IRQ_STATUS: rdata <= {6'h00, irq_status};
                rlsc_pkg::ADDR_IRQ_MASK: rdata <= {6'h00, irq_mask};
                default: rdata <= 8'h00;
            endcase
        end
        else
            rdata <= 8'h00;
    end
endmodule : rlsc_top
`default_nettype wire

/* File: pkg/rlsc_pkg.sv */
// Constants and carriers for the wakeup timer and brownout control block.
// Assumes a single 25 MHz system clock and an 8-bit register port.
`default_nettype none
package rlsc_pkg;
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned SLOW_HZ = 1000;
    localparam int unsigned FAST_HZ = 32768;
    localparam logic [3:0] ADDR_WAKEUP = 4'h0;
    localparam logic [3:0] ADDR_BROWNOUT = 4'h1;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h2;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
    localparam int unsigned B_FLAG = 7;
    localparam int unsigned B_ACK = 6;
    localparam int unsigned B_CLKSEL = 5;
    localparam int unsigned B_WIRQEN = 4;
    localparam int unsigned B_BIRQEN = 5;
    localparam int unsigned B_RSTEN = 4;
    localparam int unsigned B_STOPEN = 3;
    localparam int unsigned B_MASTER = 2;
    localparam int unsigned B_BGBUF = 0;
    localparam logic [7:0] WAKEUP_RESET = 8'h00;
    localparam logic [7:0] BROWNOUT_RESET = 8'h00;
    localparam logic [1:0] IRQ_WAKEUP = 2'h1;
    localparam logic [1:0] IRQ_BROWNOUT = 2'h2;
    localparam logic [2:0] PERIOD_OFF = 3'h0;
    localparam int unsigned COUNT_W_MIN = 16;
    localparam logic [15:0] SLOW_LEN_1 = 16'h0008;
    localparam logic [15:0] SLOW_LEN_2 = 16'h0020;
    localparam logic [15:0] SLOW_LEN_3 = 16'h0040;
    localparam logic [15:0] SLOW_LEN_4 = 16'h0080;
    localparam logic [15:0] SLOW_LEN_5 = 16'h0100;
    localparam logic [15:0] SLOW_LEN_6 = 16'h0200;
    localparam logic [15:0] SLOW_LEN_7 = 16'h0400;
    localparam logic [15:0] FAST_LEN_1 = 16'h0100;
    localparam logic [15:0] FAST_LEN_2 = 16'h0400;
    localparam logic [15:0] FAST_LEN_3 = 16'h0800;
    localparam logic [15:0] FAST_LEN_4 = 16'h1000;
    localparam logic [15:0] FAST_LEN_5 = 16'h2000;
    localparam logic [15:0] FAST_LEN_6 = 16'h4000;
    localparam logic [15:0] FAST_LEN_7 = 16'h8000;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rlsc_bus_s;
endpackage : rlsc_pkg
`default_nettype wire
